//--- inc/sfbfe_params.svh
// Constants of the serial flash bus front end: opcodes, lane counts, delays and timings.
`ifndef SFBFE_PARAMS_SVH
`define SFBFE_PARAMS_SVH

// Instruction opcodes; the four multi-lane read codes are fixed, the rest are chosen values.
`define SFBFE_OP_WR_ENABLE 8'h06
`define SFBFE_OP_WR_DISABLE 8'h04
`define SFBFE_OP_STAT_RD_LO 8'h05
`define SFBFE_OP_STAT_RD_HI 8'h35
`define SFBFE_OP_STAT_WRITE 8'h01
`define SFBFE_OP_READ 8'h03
`define SFBFE_OP_FAST_READ 8'h0B
`define SFBFE_OP_DUAL_OUT_READ 8'h3B
`define SFBFE_OP_DUAL_IO_READ 8'hBB
`define SFBFE_OP_QUAD_OUT_READ 8'h6B
`define SFBFE_OP_QUAD_IO_READ 8'hEB
`define SFBFE_OP_PAGE_WRITE 8'h02
`define SFBFE_OP_PAGE_ERASE 8'h81
`define SFBFE_OP_SECTOR_ERASE 8'h20
`define SFBFE_OP_BLOCK32_ERASE 8'h52
`define SFBFE_OP_BLOCK_ERASE 8'hD8
`define SFBFE_OP_CHIP_ERASE 8'h60
`define SFBFE_OP_CHIP_ERASE_ALT 8'hC7

// Lane counts and dummy clocks after the address.
`define SFBFE_LANES_1 3'h1
`define SFBFE_LANES_2 3'h2
`define SFBFE_LANES_4 3'h4
`define SFBFE_DUMMY_FAST 4'h8
`define SFBFE_DUMMY_DUAL_IO 4'h4
`define SFBFE_DUMMY_QUAD_IO 4'h6

// Reset value of the status word.
`define SFBFE_STATUS_RESET 16'h0000

// Timing: clock period and operation times in their own units.
`define SFBFE_CLK_PERIOD_NS 40
`define SFBFE_T_PAGE_WRITE_US 2000
`define SFBFE_T_ERASE_US 10000
`define SFBFE_T_STAT_WRITE_US 5000

`endif

//--- inc/sfbfe_pkg.sv
// Types and decode functions of the serial flash bus front end.
package sfbfe_pkg;
  `include "sfbfe_params.svh"

  // Status word, bit 15 down to bit 0.
  typedef struct packed {
    logic erase_suspended;
    logic protect_complement;
    logic [2:0] otp_lock;
    logic program_suspended;
    logic quad_enable;
    logic status_lock_bit1;
    logic status_lock_bit0;
    logic [4:0] protect_field;
    logic write_enable_latch;
    logic busy_flag;
  } sfbfe_status_type;

  // Per-frame state of the link logic.
  typedef enum logic [5:0] {
    LS_OPC = 6'h01,
    LS_ADDR = 6'h02,
    LS_DUMMY = 6'h04,
    LS_DATA = 6'h08,
    LS_ACT = 6'h10,
    LS_STBY = 6'h20
  } sfbfe_lstate_type;

  // Operation state of the core.
  typedef enum logic [1:0] {
    CS_IDLE = 2'h1,
    CS_BUSY = 2'h2
  } sfbfe_cstate_type;

  // Result of decoding an opcode at the link.
  typedef struct packed {
    logic valid;
    logic rd;
    logic wr;
    logic quad;
    logic [1:0] src;
    logic [2:0] inl;
    logic [2:0] outl;
    logic [3:0] dummy;
  } sfbfe_dec_type;

  // Classifies an opcode and gives its lane widths and dummy clocks.
  function automatic sfbfe_dec_type sfbfe_decode(input logic [7:0] op);
    sfbfe_dec_type d;
    d = '0;
    d.inl = `SFBFE_LANES_1;
    d.outl = `SFBFE_LANES_1;
    case (op)
      `SFBFE_OP_READ: d.rd = 1'b1;
      `SFBFE_OP_FAST_READ:
      begin
        d.rd = 1'b1;
        d.dummy = `SFBFE_DUMMY_FAST;
      end
      `SFBFE_OP_DUAL_OUT_READ:
      begin
        d.rd = 1'b1;
        d.outl = `SFBFE_LANES_2;
        d.dummy = `SFBFE_DUMMY_FAST;
      end
      `SFBFE_OP_DUAL_IO_READ:
      begin
        d.rd = 1'b1;
        d.inl = `SFBFE_LANES_2;
        d.outl = `SFBFE_LANES_2;
        d.dummy = `SFBFE_DUMMY_DUAL_IO;
      end
      `SFBFE_OP_QUAD_OUT_READ:
      begin
        d.rd = 1'b1;
        d.quad = 1'b1;
        d.outl = `SFBFE_LANES_4;
        d.dummy = `SFBFE_DUMMY_FAST;
      end
      `SFBFE_OP_QUAD_IO_READ:
      begin
        d.rd = 1'b1;
        d.quad = 1'b1;
        d.inl = `SFBFE_LANES_4;
        d.outl = `SFBFE_LANES_4;
        d.dummy = `SFBFE_DUMMY_QUAD_IO;
      end
      `SFBFE_OP_STAT_RD_LO: d.src = 2'h1;
      `SFBFE_OP_STAT_RD_HI: d.src = 2'h2;
      `SFBFE_OP_WR_ENABLE, `SFBFE_OP_WR_DISABLE, `SFBFE_OP_STAT_WRITE, `SFBFE_OP_PAGE_WRITE,
      `SFBFE_OP_PAGE_ERASE, `SFBFE_OP_SECTOR_ERASE, `SFBFE_OP_BLOCK32_ERASE, `SFBFE_OP_BLOCK_ERASE,
      `SFBFE_OP_CHIP_ERASE, `SFBFE_OP_CHIP_ERASE_ALT: d.wr = 1'b1;
      default: d.wr = 1'b0;
    endcase
    d.valid = d.rd | d.wr | (d.src != 2'h0);
    return d;
  endfunction

  // Last clock index of the 24-bit address phase for a lane count.
  function automatic logic [4:0] sfbfe_addr_last(input logic [2:0] lanes);
    case (lanes)
      `SFBFE_LANES_2: return 5'h0B;
      `SFBFE_LANES_4: return 5'h05;
      default: return 5'h17;
    endcase
  endfunction

  // Last clock index within one output byte for a lane count.
  function automatic logic [2:0] sfbfe_byte_last(input logic [2:0] lanes);
    case (lanes)
      `SFBFE_LANES_2: return 3'h3;
      `SFBFE_LANES_4: return 3'h1;
      default: return 3'h7;
    endcase
  endfunction
endpackage

//--- logic/sfbfe_front_end.sv
// Serial flash bus front end: serial link logic, status word and operation timing.
`timescale 1ns/1ps
`default_nettype none
module sfbfe_front_end #(
  parameter int PAGE_WRITE_CYCLES = (`SFBFE_T_PAGE_WRITE_US * 1000 + `SFBFE_CLK_PERIOD_NS - 1) / `SFBFE_CLK_PERIOD_NS,
  parameter int ERASE_CYCLES = (`SFBFE_T_ERASE_US * 1000 + `SFBFE_CLK_PERIOD_NS - 1) / `SFBFE_CLK_PERIOD_NS,
  parameter int STAT_WRITE_CYCLES = (`SFBFE_T_STAT_WRITE_US * 1000 + `SFBFE_CLK_PERIOD_NS - 1) / `SFBFE_CLK_PERIOD_NS
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Serial link from the host.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dl_i,
  output logic [3:0] dl_o,
  output logic [3:0] dl_oe,
  // Memory array read port, on the serial clock.
  output logic [23:0] array_addr,
  input wire logic [7:0] array_rdata,
  // Status word as held by the core.
  output sfbfe_pkg::sfbfe_status_type status_word
);
  import sfbfe_pkg::*;

  sfbfe_status_type stat_q;
  sfbfe_status_type stat_s1_q;
  sfbfe_status_type stat_s2_q;
  sfbfe_lstate_type lst_q;
  sfbfe_cstate_type cst_q;
  sfbfe_dec_type dec_now;
  logic link_rst;
  logic hold_now;
  logic qe_s;
  logic busy_s;
  logic [7:0] op_now;
  logic [23:0] sh_next;
  logic first_q;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  logic [23:0] addr_q;
  logic [2:0] inl_q;
  logic [2:0] outl_q;
  logic [3:0] dum_q;
  logic [1:0] src_q;
  logic [2:0] dcnt_q;
  logic [7:0] oreg_q;
  logic oe_q;
  logic tgl_q;
  logic [2:0] fbit_q;
  logic [2:0] fbyt_q;
  logic [7:0] fop_q;
  logic [15:0] fdat_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_prev_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic seen_q;
  logic wp_s1_q;
  logic wp_s2_q;
  logic cmd_ok;
  logic locked;
  logic [19:0] busy_cnt_q;

  // Select high, or the core reset, clears the sequencing and output state of the link at once.
  assign link_rst = cs_n | ~rstn;
  assign qe_s = stat_s2_q.quad_enable;
  assign busy_s = stat_s2_q.busy_flag;

  // The pause pin is read directly: low clock lets it act at once, a high clock defers it to the
  // next edge, which is exactly when both processes look at it.
  assign hold_now = ~qe_s & ~dl_i[3];

  // Opcode as it stands after the eighth rising edge, most significant bit first.
  assign op_now = {sh_q[6:0], dl_i[0]};
  assign dec_now = sfbfe_decode(op_now);

  // Input shift for the lane count of the current phase.
  always_comb
  begin
    case (inl_q)
      `SFBFE_LANES_2: sh_next = {sh_q[21:0], dl_i[1], dl_i[0]};
      `SFBFE_LANES_4: sh_next = {sh_q[19:0], dl_i[3], dl_i[2], dl_i[1], dl_i[0]};
      default: sh_next = {sh_q[22:0], dl_i[0]};
    endcase
  end

  // Status word crosses into the link domain bit by bit; commands change it between frames, but an operation end
  // clears busy and the write enable latch at any time, even inside a frame.
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_s1_q <= `SFBFE_STATUS_RESET;
      stat_s2_q <= `SFBFE_STATUS_RESET;
    end
    else
    begin
      stat_s1_q <= stat_q;
      stat_s2_q <= stat_s1_q;
    end
  end

  // Link sequencing on the rising edge; nothing moves while paused.
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      first_q <= 1'b0;
      lst_q <= LS_OPC;
      cnt_q <= 5'h00;
      sh_q <= 24'h000000;
      addr_q <= 24'h000000;
      inl_q <= `SFBFE_LANES_1;
      outl_q <= `SFBFE_LANES_1;
      dum_q <= 4'h0;
      src_q <= 2'h0;
      dcnt_q <= 3'h0;
    end
    else if (!hold_now)
    begin
      first_q <= 1'b1;
      case (lst_q)
        LS_OPC:
        begin
          sh_q <= {sh_q[22:0], dl_i[0]};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h07)
          begin
            cnt_q <= 5'h00;
            inl_q <= dec_now.inl;
            outl_q <= dec_now.outl;
            dum_q <= dec_now.dummy;
            src_q <= dec_now.src;
            if (!dec_now.valid || (dec_now.quad && !qe_s) || (dec_now.rd && busy_s))
              lst_q <= LS_STBY;
            else if (dec_now.src != 2'h0)
              lst_q <= LS_DATA;
            else if (dec_now.rd)
              lst_q <= LS_ADDR;
            else
              lst_q <= LS_ACT;
          end
        end
        LS_ADDR:
        begin
          sh_q <= sh_next;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == sfbfe_addr_last(inl_q))
          begin
            cnt_q <= 5'h00;
            addr_q <= sh_next;
            lst_q <= (dum_q != 4'h0) ? LS_DUMMY : LS_DATA;
          end
        end
        LS_DUMMY:
        begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == {1'b0, dum_q} - 5'h01)
          begin
            cnt_q <= 5'h00;
            lst_q <= LS_DATA;
          end
        end
        LS_DATA:
        begin
          // Output bytes follow one another; the array address steps after each byte.
          if (dcnt_q == sfbfe_byte_last(outl_q))
          begin
            dcnt_q <= 3'h0;
            addr_q <= addr_q + 24'h000001;
          end
          else
            dcnt_q <= dcnt_q + 3'h1;
        end
        LS_ACT: sh_q <= sh_q;
        LS_STBY: sh_q <= sh_q;
        default: lst_q <= LS_STBY;
      endcase
    end
  end

  // Frame record: survives select high so the core can judge the frame after it ends.
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tgl_q <= 1'b0;
      fbit_q <= 3'h0;
      fbyt_q <= 3'h0;
      fop_q <= 8'h00;
      fdat_q <= 16'h0000;
    end
    else if (!hold_now && !cs_n)
    begin
      if (!first_q)
      begin
        tgl_q <= ~tgl_q;
        fbit_q <= 3'h1;
        fbyt_q <= 3'h0;
      end
      else
      begin
        fbit_q <= fbit_q + 3'h1;
        if (fbit_q == 3'h7 && fbyt_q != 3'h7)
          fbyt_q <= fbyt_q + 3'h1;
      end
      if (lst_q == LS_OPC && cnt_q == 5'h07)
        fop_q <= op_now;
      if (lst_q == LS_ACT && fbyt_q < 3'h3)
        fdat_q <= {fdat_q[14:0], dl_i[0]};
    end
  end

  // Output shifting on the falling edge; a frame may stop after any bit.
  always_ff @(negedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      oreg_q <= 8'h00;
      oe_q <= 1'b0;
    end
    else if (!hold_now)
    begin
      if (lst_q == LS_DATA)
      begin
        oe_q <= 1'b1;
        if (dcnt_q == 3'h0)
        begin
          case (src_q)
            2'h1: oreg_q <= stat_s2_q[7:0];
            2'h2: oreg_q <= stat_s2_q[15:8];
            default: oreg_q <= array_rdata;
          endcase
        end
        else
          oreg_q <= oreg_q << outl_q;
      end
      else
        oe_q <= 1'b0;
    end
  end

  // Lane mapping of the outgoing bits; with quad enable off, drivers drop the moment the pause pin falls.
  always_comb
  begin
    case (outl_q)
      `SFBFE_LANES_2:
      begin
        dl_o = {2'h0, oreg_q[7:6]};
        dl_oe = 4'h3;
      end
      `SFBFE_LANES_4:
      begin
        dl_o = oreg_q[7:4];
        dl_oe = 4'hF;
      end
      default:
      begin
        dl_o = {2'h0, oreg_q[7], 1'b0};
        dl_oe = 4'h2;
      end
    endcase
    if (!oe_q || hold_now)
      dl_oe = 4'h0;
  end

  assign array_addr = addr_q;
  assign status_word = stat_q;

  // Core side synchronisers for select, the frame toggle and the protect pin.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_prev_q <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      seen_q <= 1'b0;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end
    else
    begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_prev_q <= cs_s2_q;
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      wp_s1_q <= dl_i[2];
      wp_s2_q <= wp_s1_q;
      if (cs_s2_q && !cs_prev_q)
        seen_q <= tgl_s2_q;
    end
  end

  // A finished frame counts only if it had clocks and ended on a whole byte.
  assign cmd_ok = cs_s2_q && !cs_prev_q && (tgl_s2_q != seen_q) && (fbit_q == 3'h0) && (fbyt_q != 3'h0);

  // With quad lines on, the protect pin is a data line and cannot lock.
  assign locked = stat_q.status_lock_bit1 | (stat_q.status_lock_bit0 & ~wp_s2_q & ~stat_q.quad_enable);

  // Status word and operation timer; the operation runs on the core clock, untouched by the link.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_q <= `SFBFE_STATUS_RESET;
      cst_q <= CS_IDLE;
      busy_cnt_q <= 20'h00000;
    end
    else
    begin
      case (cst_q)
        CS_IDLE:
        begin
          if (cmd_ok)
          begin
            case (fop_q)
              `SFBFE_OP_WR_ENABLE: stat_q.write_enable_latch <= 1'b1;
              `SFBFE_OP_WR_DISABLE: stat_q.write_enable_latch <= 1'b0;
              `SFBFE_OP_STAT_WRITE:
              begin
                if (stat_q.write_enable_latch && !locked && fbyt_q >= 3'h2)
                begin
                  // One data byte fills bits 7..2; a second fills bits 14..11, 9 and 8.
                  if (fbyt_q == 3'h2)
                  begin
                    stat_q.protect_field <= fdat_q[6:2];
                    stat_q.status_lock_bit0 <= fdat_q[7];
                  end
                  else
                  begin
                    stat_q.protect_field <= fdat_q[14:10];
                    stat_q.status_lock_bit0 <= fdat_q[15];
                    stat_q.status_lock_bit1 <= fdat_q[0];
                    stat_q.quad_enable <= fdat_q[1];
                    stat_q.otp_lock <= stat_q.otp_lock | fdat_q[5:3];
                    stat_q.protect_complement <= fdat_q[6];
                  end
                  stat_q.busy_flag <= 1'b1;
                  busy_cnt_q <= 20'(STAT_WRITE_CYCLES);
                  cst_q <= CS_BUSY;
                end
              end
              `SFBFE_OP_PAGE_WRITE:
              begin
                if (stat_q.write_enable_latch)
                begin
                  stat_q.busy_flag <= 1'b1;
                  busy_cnt_q <= 20'(PAGE_WRITE_CYCLES);
                  cst_q <= CS_BUSY;
                end
              end
              `SFBFE_OP_PAGE_ERASE, `SFBFE_OP_SECTOR_ERASE, `SFBFE_OP_BLOCK32_ERASE, `SFBFE_OP_BLOCK_ERASE:
              begin
                if (stat_q.write_enable_latch)
                begin
                  stat_q.busy_flag <= 1'b1;
                  busy_cnt_q <= 20'(ERASE_CYCLES);
                  cst_q <= CS_BUSY;
                end
              end
              `SFBFE_OP_CHIP_ERASE, `SFBFE_OP_CHIP_ERASE_ALT:
              begin
                if (stat_q.write_enable_latch && stat_q.protect_field[2:0] == 3'h0)
                begin
                  stat_q.busy_flag <= 1'b1;
                  busy_cnt_q <= 20'(ERASE_CYCLES);
                  cst_q <= CS_BUSY;
                end
              end
              default: cst_q <= CS_IDLE;
            endcase
          end
        end
        CS_BUSY:
        begin
          // Commands arriving now are dropped so the running operation is never disturbed.
          if (busy_cnt_q <= 20'h00001)
          begin
            stat_q.busy_flag <= 1'b0;
            stat_q.write_enable_latch <= 1'b0;
            cst_q <= CS_IDLE;
          end
          else
            busy_cnt_q <= busy_cnt_q - 20'h00001;
        end
        default: cst_q <= CS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/sfbfe_front_end_tb_top.sv
// Self-checking bench of the flash front end driven through the host model.
`timescale 1ns/1ps
`default_nettype none
module sfbfe_front_end_tb_top;
  import sfbfe_pkg::*;
  localparam int PW = 200;
  localparam int ER = 100;
  localparam int SW = 100;
  logic clk;
  logic rstn;
  logic sclk;
  logic cs_n;
  logic [3:0] dl_i;
  logic [3:0] dl_o;
  logic [3:0] dl_oe;
  logic [23:0] array_addr;
  logic [7:0] array_rdata;
  sfbfe_status_type status_word;
  int err_count;
  int checks;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [3:0] q;
  logic mode_q = 1'b0;

  sfbfe_front_end #(.PAGE_WRITE_CYCLES(PW), .ERASE_CYCLES(ER), .STAT_WRITE_CYCLES(SW)) dut_u (.clk(clk),
    .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .dl_i(dl_i), .dl_o(dl_o), .dl_oe(dl_oe), .array_addr(array_addr),
    .array_rdata(array_rdata), .status_word(status_word));
  sfbfe_host_model host_u (.sclk(sclk), .cs_n(cs_n), .dl_i(dl_i), .dl_o(dl_o), .dl_oe(dl_oe));

  // Core clock.
  always #20 clk = ~clk;
  // Array content follows the address, so read data is known in advance.
  always @(posedge clk) array_rdata <= array_addr[7:0] ^ 8'h5A;

  task automatic chk(input logic [15:0] act, input logic [15:0] exp, input string what);
    checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait on the busy flag; running out ends the run.
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (status_word.busy_flag !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (status_word.busy_flag !== v)
    begin
      err_count++;
      $display("FAIL %0t busy wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int nb, input logic [7:0] d, input int extra);
    host_u.start(mode_q);
    host_u.send(op);
    repeat (nb) host_u.send(d);
    repeat (extra) host_u.bit_x(1'b0, q);
    host_u.stop();
  endtask

  task automatic rd_frame(input logic [7:0] op, input int lanes, input int dummy, input logic [23:0] a);
    host_u.start(mode_q);
    host_u.send(op);
    host_u.send(a[23:16]);
    host_u.send(a[15:8]);
    host_u.send(a[7:0]);
    repeat (dummy) host_u.bit_x(1'b0, q);
    host_u.recv(lanes, b1);
    host_u.recv(lanes, b2);
    host_u.stop();
  endtask

  task automatic t_unknown();
    host_u.start(1'b0);
    host_u.send(8'hFF);
    host_u.send(`SFBFE_OP_STAT_RD_LO);
    host_u.recv(1, b1);
    chk(host_u.oe_seen, 4'h0, "unknown opcode answered");
    host_u.stop();
    $display("test unknown done");
  endtask

  // Status read after write enable, then a stop in mid byte.
  task automatic t_status(input logic mode3);
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    host_u.start(mode3);
    host_u.send(`SFBFE_OP_STAT_RD_LO);
    host_u.recv(1, b1);
    chk(host_u.oe_seen, 4'h2, "status read lane");
    chk(b1, 8'h02, "status read value");
    repeat (3) host_u.bit_x(1'b0, q);
    host_u.stop();
    chk(dl_oe, 4'h0, "lines after early stop");
    $display("test status done");
  endtask

  task automatic t_pause();
    host_u.start(1'b0);
    host_u.send(`SFBFE_OP_STAT_RD_LO);
    host_u.recv(1, b1);
    host_u.pause(1'b0);
    chk(dl_oe, 4'h0, "output during pause");
    host_u.pause(1'b1);
    host_u.recv(1, b2);
    chk(b2, 8'h02, "status after pause");
    host_u.stop();
    $display("test pause done");
  endtask

  task automatic t_latch();
    rd_frame(`SFBFE_OP_QUAD_OUT_READ, 4, 8, 24'h000010);
    chk(host_u.oe_seen, 4'h0, "quad read without enable");
    cmd(`SFBFE_OP_WR_DISABLE, 0, 8'h00, 0);
    chk(status_word.write_enable_latch, 1'b0, "latch not cleared");
    cmd(`SFBFE_OP_PAGE_WRITE, 4, 8'h00, 0);
    repeat (10) @(posedge clk);
    chk(status_word.busy_flag, 1'b0, "write without latch");
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    cmd(`SFBFE_OP_PAGE_WRITE, 4, 8'h00, 1);
    repeat (10) @(posedge clk);
    chk(status_word.busy_flag, 1'b0, "write off byte boundary");
    $display("test latch done");
  endtask

  task automatic t_page();
    cmd(`SFBFE_OP_PAGE_WRITE, 4, 8'h00, 0);
    wait_busy(1'b1, 10);
    rd_frame(`SFBFE_OP_READ, 1, 0, 24'h000000);
    chk(host_u.oe_seen, 4'h0, "array read while busy");
    chk(status_word.busy_flag, 1'b1, "operation disturbed");
    wait_busy(1'b0, PW + 20);
    chk(status_word.write_enable_latch, 1'b0, "latch after write");
    $display("test page done");
  endtask

  // Successful status write: enable, frame, then the whole busy stretch.
  task automatic stat_wr(input logic [7:0] lo);
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    cmd(`SFBFE_OP_STAT_WRITE, 1, lo, 0);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, SW + 20);
  endtask

  task automatic t_protect();
    stat_wr(8'h1C);
    chk(status_word.protect_field, 5'h07, "protect field");
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    cmd(`SFBFE_OP_CHIP_ERASE, 0, 8'h00, 0);
    repeat (10) @(posedge clk);
    chk(status_word.busy_flag, 1'b0, "chip erase while protected");
    stat_wr(8'h80);
    host_u.host_q[2] = 1'b0;
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    cmd(`SFBFE_OP_STAT_WRITE, 1, 8'h00, 0);
    repeat (10) @(posedge clk);
    chk(status_word.status_lock_bit0, 1'b1, "locked status written");
    host_u.host_q[2] = 1'b1;
    stat_wr(8'h00);
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    cmd(`SFBFE_OP_CHIP_ERASE_ALT, 0, 8'h00, 0);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, ER + 20);
    $display("test protect done");
  endtask

  task automatic t_multi();
    cmd(`SFBFE_OP_WR_ENABLE, 0, 8'h00, 0);
    host_u.start(1'b0);
    host_u.send(`SFBFE_OP_STAT_WRITE);
    host_u.send(8'h00);
    host_u.send(8'h02);
    host_u.stop();
    wait_busy(1'b1, 10);
    wait_busy(1'b0, SW + 20);
    chk(status_word.quad_enable, 1'b1, "quad enable");
    rd_frame(`SFBFE_OP_QUAD_OUT_READ, 4, 8, 24'h000010);
    chk(b1, 8'h4A, "quad data");
    chk(host_u.oe_seen, 4'hF, "quad lanes");
    host_u.host_q[3] = 1'b0;
    rd_frame(`SFBFE_OP_DUAL_OUT_READ, 2, 8, 24'h000021);
    host_u.host_q[3] = 1'b1;
    chk(b1, 8'h7B, "dual data first");
    chk(b2, 8'h78, "dual data next");
    chk(host_u.oe_seen, 4'h3, "dual lanes");
    $display("test multi done");
  endtask

  // Reset with two link clocks inside it, then the scenarios in order.
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    array_rdata = 8'h00;
    err_count = 0;
    checks = 0;
    fork
      begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
      end
      begin
        #7;
        host_u.bit_x(1'b0, q);
        host_u.bit_x(1'b0, q);
      end
    join
    repeat (4) @(posedge clk);
    chk(status_word, 16'h0000, "status reset value");
    chk(dl_oe, 4'h0, "lines after reset");
    t_unknown();
    t_status(1'b0);
    t_status(1'b1);
    t_pause();
    t_latch();
    t_page();
    mode_q = 1'b1;
    t_protect();
    t_multi();
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- verification/sfbfe_host_model.sv
// Host serial bus controller model that drives the link of the front end.
`timescale 1ns/1ps
`default_nettype none
module sfbfe_host_model (
  // Link towards the device.
  output var logic sclk,
  output var logic cs_n,
  output logic [3:0] dl_i,
  input wire logic [3:0] dl_o,
  input wire logic [3:0] dl_oe
);
  logic [3:0] host_q;
  logic [3:0] oe_seen;
  logic idle_hi;

  // A lane shows the device value while it drives; line 1 toggles when released.
  assign dl_i = (dl_oe & dl_o) | (~dl_oe & host_q);

  // Idle: deselected, protect and pause pins pulled high.
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_q = 4'hC;
    oe_seen = 4'h0;
    idle_hi = 1'b0;
  end

  // One clock: data set while low, sampled by the device at the rise.
  task automatic bit_x(input logic d, output logic [3:0] q);
    sclk = 1'b0;
    host_q[0] = d;
    host_q[1] = ~host_q[1];
    #40;
    q = dl_o;
    oe_seen = dl_oe;
    sclk = 1'b1;
    #40;
  endtask

  // The offset keeps link edges away from core clock edges.
  task automatic start(input logic mode3);
    #7;
    idle_hi = mode3;
    sclk = mode3;
    #40;
    cs_n = 1'b0;
    #40;
  endtask

  // Opcode and address bytes go most significant bit first.
  task automatic send(input logic [7:0] b);
    logic [3:0] q;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], q);
  endtask

  // Collects one byte over one, two or four lanes.
  task automatic recv(input int lanes, output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int i = 0; i < 8 / lanes; i++)
    begin
      bit_x(~host_q[0], q);
      if (lanes == 4)
        b = {b[3:0], q};
      else if (lanes == 2)
        b = {b[5:0], q[1:0]};
      else
        b = {b[6:0], q[1]};
    end
  endtask

  // Release gap covers the three core clocks the device needs between frames.
  task automatic stop();
    sclk = idle_hi;
    #40;
    cs_n = 1'b1;
    #200;
  endtask

  // Pause pin moves only while the clock is low.
  task automatic pause(input logic v);
    sclk = 1'b0;
    #20;
    host_q[3] = v;
    #40;
  endtask
endmodule
`default_nettype wire

//--- verification/sfbfe_monitor.sv
// Port checker of the serial flash bus front end, bound to the design top.
`timescale 1ns/1ps
`default_nettype none
module sfbfe_monitor #(
  parameter int PAGE_WRITE_CYCLES = 20,
  parameter int ERASE_CYCLES = 20,
  parameter int STAT_WRITE_CYCLES = 20
) (
  // Core clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Serial link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dl_i,
  input wire logic [3:0] dl_o,
  input wire logic [3:0] dl_oe,
  // Array port and status word.
  input wire logic [23:0] array_addr,
  input wire logic [7:0] array_rdata,
  input wire sfbfe_pkg::sfbfe_status_type status_word
);
  import sfbfe_pkg::*;
  localparam int LIM_AB = (PAGE_WRITE_CYCLES > ERASE_CYCLES) ? PAGE_WRITE_CYCLES : ERASE_CYCLES;
  localparam int BUSY_LIMIT = ((LIM_AB > STAT_WRITE_CYCLES) ? LIM_AB : STAT_WRITE_CYCLES) + 8;
  logic [31:0] busy_cnt_q;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Length of the current busy stretch; a stuck busy flag runs it past the limit.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      busy_cnt_q <= 32'h0;
    else if (status_word.busy_flag)
      busy_cnt_q <= busy_cnt_q + 32'h1;
    else
      busy_cnt_q <= 32'h0;
  end

  // An operation starts and then holds its busy flag for a while.
  sequence s_busy_start;
    $rose(status_word.busy_flag);
  endsequence
  sequence s_busy_hold;
    status_word.busy_flag [*8];
  endsequence

  property p_desel_float;
    cs_n |-> dl_oe == 4'h0;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("lines driven while deselected");
  property p_pause_float;
    (!status_word.quad_enable && !dl_i[3] && !cs_n) |-> dl_oe == 4'h0;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("lines driven while paused");
  property p_oe_legal;
    dl_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_oe_legal: assert property (p_oe_legal) else $error("illegal lane enable set");
  property p_quad_qe;
    dl_oe[3] |-> status_word.quad_enable;
  endproperty
  a_quad_qe: assert property (p_quad_qe) else $error("quad lanes without quad enable");
  property p_busy_min;
    s_busy_start |-> s_busy_hold;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy flag too short");
  property p_busy_max;
    status_word.busy_flag |-> busy_cnt_q <= BUSY_LIMIT;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy flag stuck");
  property p_busy_wel;
    s_busy_start |-> $past(status_word.write_enable_latch);
  endproperty
  a_busy_wel: assert property (p_busy_wel) else $error("operation without write enable");
  property p_protect_busy;
    $changed(status_word.protect_field) |-> status_word.busy_flag || $past(status_word.busy_flag)
      || $past(status_word.busy_flag, 2);
  endproperty
  a_protect_busy: assert property (p_protect_busy) else $error("protect field changed outside a write");
endmodule

bind sfbfe_front_end sfbfe_monitor #(.PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
  .STAT_WRITE_CYCLES(STAT_WRITE_CYCLES)) mon_u (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .dl_i(dl_i),
  .dl_o(dl_o), .dl_oe(dl_oe), .array_addr(array_addr), .array_rdata(array_rdata), .status_word(status_word));
`default_nettype wire
